// [design/ccs_pkg.sv]
// Shared constants for the core clock source selection block.
package ccs_pkg;
  // System clock rate
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_FREQ_MHZ = 1000 / CLK_PERIOD_NS;
  // Core master clock from the PLL runs at this multiple of the oscillator
  localparam int PLL_MULT = 5;
  localparam int PER_W = 16;
  localparam logic [PER_W-1:0] PLL_MULT_V = PER_W'(PLL_MULT);
  localparam logic [PER_W-1:0] PER_MAX = {PER_W{1'b1}};
  localparam logic [PER_W-1:0] PER_ZERO = {PER_W{1'b0}};
  localparam logic [PER_W-1:0] PER_ONE = PER_W'(1);
  // Reference edges seen before the multiplier is trusted
  localparam int LOCK_EDGES = 2;
  localparam logic [1:0] LOCK_EDGES_V = 2'(LOCK_EDGES);
  // Divided clock periods per instruction cycle
  localparam int INSTR_DIV = 2;
  localparam int INSTR_W = 4;
  localparam logic [INSTR_W-1:0] INSTR_LAST = INSTR_W'(INSTR_DIV - 1);
  localparam logic [INSTR_W-1:0] INSTR_ZERO = {INSTR_W{1'b0}};
  // Clock source select levels
  localparam logic SRC_PLL = 1'b0;
  localparam logic SRC_EXT = 1'b1;
endpackage

// [design/ccs_pll_mult.sv]
// Frequency multiplier: PLL_MULT tick pulses per reference period.
`timescale 1ns/10ps
module ccs_pll_mult (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic ref_rise,
  output logic tick_q,
  output logic locked_q
);
  import ccs_pkg::*;

  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] period_q;
  logic [PER_W-1:0] acc_q;
  logic [PER_W-1:0] acc_d;
  logic [PER_W:0] acc_sum;
  logic [1:0] edges_q;
  logic tick_d;

  // Period of the reference measured in system cycles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_q <= PER_ZERO;
      period_q <= PER_MAX;
    end else if (!enable) begin
      per_cnt_q <= PER_ZERO;
    end else if (ref_rise) begin
      per_cnt_q <= PER_ZERO;
      period_q <= per_cnt_q + PER_ONE;
    end else if (per_cnt_q != PER_MAX) begin
      per_cnt_q <= per_cnt_q + PER_ONE;
    end
  end

  // Lost reference drops lock; a stalled oscillator gives no ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      edges_q <= 2'h0;
    end else if (!enable || per_cnt_q == PER_MAX) begin
      edges_q <= 2'h0;
    end else if (ref_rise && edges_q != LOCK_EDGES_V) begin
      edges_q <= edges_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= enable && edges_q == LOCK_EDGES_V &&
                  per_cnt_q != PER_MAX;
    end
  end

  // Fractional accumulator keeps exactly PLL_MULT ticks per period.
  // Needs a reference period of at least PLL_MULT system cycles.
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, PLL_MULT_V};
    tick_d = 1'b0;
    acc_d = acc_sum[PER_W-1:0];
    if (!locked_q) begin
      acc_d = PER_ZERO;
    end else if (acc_sum >= {1'b0, period_q}) begin
      tick_d = 1'b1;
      acc_d = PER_W'(acc_sum - {1'b0, period_q});
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= PER_ZERO;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  no_tick_unlocked_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !locked_q |=> !tick_q)
    else $error("multiplier ticked while unlocked");

  tick_off_disabled_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !enable [*3] |-> !tick_q)
    else $error("multiplier ticked while disabled");
endmodule

// [design/ccs_core_clock_source_select.sv]
// Core master clock source selection, divided clock and cycle marker.
`timescale 1ns/10ps
module ccs_core_clock_source_select (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clock_source_select,
  input wire logic oscillator_input,
  input wire logic master_clock_input,
  output logic oscillator_output,
  output logic pll_enabled,
  output logic core_clock_tick,
  output logic divided_clock_output,
  output logic instruction_cycle_marker
);
  import ccs_pkg::*;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur && !prev;
  endfunction

  logic sel_m_q;
  logic sel_s_q;
  logic sel_q;
  logic osc_m_q;
  logic osc_s_q;
  logic osc_h_q;
  logic mclk_m_q;
  logic mclk_s_q;
  logic mclk_h_q;
  logic osc_rise;
  logic mclk_rise;
  logic restart;
  logic pll_tick;
  logic pll_locked;
  logic master_tick;
  logic pll_en_q;
  logic osc_out_q;
  logic tick_q;
  logic div_q;
  logic marker_q;
  logic [INSTR_W-1:0] instr_cnt_q;

  // Every pin passes two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_m_q <= SRC_PLL;
      sel_s_q <= SRC_PLL;
      sel_q <= SRC_PLL;
    end else begin
      sel_m_q <= clock_source_select;
      sel_s_q <= sel_m_q;
      sel_q <= sel_s_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_m_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_h_q <= 1'b0;
    end else begin
      osc_m_q <= oscillator_input;
      osc_s_q <= osc_m_q;
      osc_h_q <= osc_s_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mclk_m_q <= 1'b0;
      mclk_s_q <= 1'b0;
      mclk_h_q <= 1'b0;
    end else begin
      mclk_m_q <= master_clock_input;
      mclk_s_q <= mclk_m_q;
      mclk_h_q <= mclk_s_q;
    end
  end

  assign osc_rise = rise(osc_s_q, osc_h_q);
  assign mclk_rise = rise(mclk_s_q, mclk_h_q);
  // A source change restarts the divider so no short half period leaks
  assign restart = sel_s_q != sel_q;

  // Oscillator and PLL run only with the select low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pll_en_q <= 1'b0;
      osc_out_q <= 1'b0;
    end else begin
      pll_en_q <= sel_s_q == SRC_PLL;
      osc_out_q <= (sel_s_q == SRC_PLL) && !osc_s_q;
    end
  end

  ccs_pll_mult u_pll (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(pll_en_q),
    .ref_rise(osc_rise),
    .tick_q(pll_tick),
    .locked_q(pll_locked)
  );

  // Master clock enable from whichever source is selected
  assign master_tick = restart ? 1'b0 :
                       (sel_q == SRC_EXT) ? mclk_rise :
                       (pll_tick && pll_en_q);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= master_tick;
    end
  end

  // One toggle per master tick gives half the master rate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 1'b0;
    end else if (restart) begin
      div_q <= 1'b0;
    end else if (master_tick) begin
      div_q <= !div_q;
    end
  end

  // Marker only changes on a divided clock rising edge or a restart
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      instr_cnt_q <= INSTR_ZERO;
      marker_q <= 1'b0;
    end else if (restart) begin
      instr_cnt_q <= INSTR_ZERO;
      marker_q <= 1'b0;
    end else if (master_tick && !div_q) begin
      marker_q <= instr_cnt_q == INSTR_ZERO;
      if (instr_cnt_q == INSTR_LAST) begin
        instr_cnt_q <= INSTR_ZERO;
      end else begin
        instr_cnt_q <= instr_cnt_q + INSTR_W'(1);
      end
    end
  end

  assign oscillator_output = osc_out_q;
  assign pll_enabled = pll_en_q;
  assign core_clock_tick = tick_q;
  assign divided_clock_output = div_q;
  assign instruction_cycle_marker = marker_q;

  sequence div_rise_s;
    $rose(div_q);
  endsequence

  sequence restarted_s;
    $past(restart);
  endsequence

  pll_on_low_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_s_q == SRC_PLL |=> pll_en_q)
    else $error("PLL not enabled with select low");

  pll_off_high_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_EXT |-> !pll_en_q)
    else $error("PLL enabled with select high");

  ext_tick_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_EXT && !restart && mclk_rise |=> tick_q)
    else $error("external clock edge not passed to core");

  pll_tick_path_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_PLL && !restart && pll_tick && pll_en_q |=> tick_q)
    else $error("PLL tick not passed to core");

  div_half_rate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(div_q) |-> tick_q or restarted_s)
    else $error("divided clock moved without a master tick");

  div_follow_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    tick_q && !$past(restart) |-> div_q != $past(div_q))
    else $error("divided clock missed a master tick");

  marker_edge_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $changed(marker_q) |-> div_rise_s or restarted_s)
    else $error("marker changed off a divided clock rise");

  marker_one_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    marker_q and div_rise_s |-> !$past(marker_q))
    else $error("marker held beyond one divided period");

  no_src_no_div_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    !master_tick && !restart |=> $stable(div_q))
    else $error("divided clock moved with no selected source edge");

  osc_off_high_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_EXT |-> !osc_out_q)
    else $error("oscillator driven with select high");

  // PLL ticks must not leak into the core while the external clock rules
  ext_only_tick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_EXT && !mclk_rise |=> !tick_q)
    else $error("core tick without an external clock edge");

  pll_only_tick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    sel_q == SRC_PLL && !pll_tick |=> !tick_q)
    else $error("core tick without a PLL tick");

  restart_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    restart |=> !tick_q && !div_q && !marker_q)
    else $error("source change did not restart the dividers");
endmodule

// [testbench/ccs_src_model.sv]
// Behavioural crystal and external clock generator feeding the block.
`timescale 1ns/10ps
module ccs_src_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic osc_run,
  input wire logic mclk_run,
  input wire logic [7:0] osc_half,
  input wire logic [7:0] mclk_half,
  output logic oscillator_input,
  output logic master_clock_input
);
  logic [7:0] osc_cnt_q;
  logic [7:0] mclk_cnt_q;
  // Stopped sources stand low, as an idle generator would
  always_ff @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt_q <= 8'h00;
      oscillator_input <= 1'b0;
    end else if (!osc_run) begin
      oscillator_input <= 1'b0;
    end else if (osc_cnt_q >= osc_half - 8'h01) begin
      osc_cnt_q <= 8'h00;
      oscillator_input <= ~oscillator_input;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end
  always_ff @(negedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mclk_cnt_q <= 8'h00;
      master_clock_input <= 1'b0;
    end else if (!mclk_run) begin
      master_clock_input <= 1'b0;
    end else if (mclk_cnt_q >= mclk_half - 8'h01) begin
      mclk_cnt_q <= 8'h00;
      master_clock_input <= ~master_clock_input;
    end else begin
      mclk_cnt_q <= mclk_cnt_q + 8'h01;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the core clock source selection block.
`timescale 1ns/10ps
module tb_top;
  import ccs_pkg::*;
  logic clk_sys, rst_b, sel, osc_run, mclk_run;
  logic [7:0] osc_half, mclk_half;
  logic osc_in, mclk_in, osc_out, pll_en, tick, div_clk, marker;
  int n_errors, check_count, cycles, tk, dr, mr, orr, w;
  logic d_at;
  ccs_core_clock_source_select i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .clock_source_select(sel), .oscillator_input(osc_in),
    .master_clock_input(mclk_in), .oscillator_output(osc_out),
    .pll_enabled(pll_en), .core_clock_tick(tick),
    .divided_clock_output(div_clk), .instruction_cycle_marker(marker));
  ccs_src_model i_src (.clk_sys(clk_sys), .rst_b(rst_b),
    .osc_run(osc_run), .mclk_run(mclk_run), .osc_half(osc_half),
    .mclk_half(mclk_half), .oscillator_input(osc_in),
    .master_clock_input(mclk_in));
  initial begin
    clk_sys = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic check_num(string name, int exp, int got);
    check_count++;
    if (got != exp) begin
      n_errors++;
      $display("wrong value %s exp %0d got %0d", name, exp, got);
    end
  endtask
  // Counts ticks and rising edges over a window of n cycles
  task automatic measure(int n);
    logic pd, pm, po;
    tk = 0; dr = 0; mr = 0; orr = 0;
    pd = div_clk; pm = marker; po = osc_out;
    repeat (n) begin
      @(negedge clk_sys);
      if (tick === 1'b1) tk++;
      if (div_clk === 1'b1 && pd === 1'b0) dr++;
      if (marker === 1'b1 && pm === 1'b0) mr++;
      if (osc_out === 1'b1 && po === 1'b0) orr++;
      pd = div_clk; pm = marker; po = osc_out;
    end
  endtask
  task automatic marker_width;
    w = 0;
    // Skip a pulse already under way, its width would come out short
    while (marker === 1'b1) @(negedge clk_sys);
    while (marker !== 1'b1) @(negedge clk_sys);
    d_at = div_clk;
    while (marker === 1'b1) begin
      w++;
      @(negedge clk_sys);
    end
  endtask
  // Master clock period 8, oscillator period 10 running but unused
  task automatic test_ext;
    sel = SRC_EXT; mclk_run = 1'b1; osc_run = 1'b1;
    repeat (60) @(negedge clk_sys);
    check_bit("pll_en", 1'b0, pll_en);
    check_bit("osc_out", 1'b0, osc_out);
    measure(160);
    check_num("ext ticks", 20, tk);
    check_num("ext div", 10, dr);
    check_num("ext marks", 10 / INSTR_DIV, mr);
    marker_width();
    check_num("ext mark width", 16, w);
    check_bit("div at mark", 1'b1, d_at);
    mclk_run = 1'b0;
    repeat (10) @(negedge clk_sys);
    measure(100);
    check_num("ext stopped", 0, tk);
  endtask
  task automatic test_pll;
    sel = SRC_PLL; mclk_run = 1'b1;
    repeat (100) @(negedge clk_sys);
    check_bit("pll_en", 1'b1, pll_en);
    measure(100);
    check_num("pll ticks", 10 * PLL_MULT, tk);
    check_num("pll div", 10 * PLL_MULT / 2, dr);
    check_num("osc out", 10, orr);
    marker_width();
    check_num("pll mark width", 4, w);
    check_bit("div at mark", 1'b1, d_at);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    rst_b = 1'b0; sel = SRC_EXT; osc_run = 1'b0; mclk_run = 1'b0;
    osc_half = 8'h05; mclk_half = 8'h04;
    repeat (2) @(negedge clk_sys);
    check_bit("div in reset", 1'b0, div_clk);
    check_bit("mark in reset", 1'b0, marker);
    rst_b = 1'b1;
    test_ext();
    test_pll();
    stop_test();
  end
endmodule
